// [rtl/flash_port_pkg.sv]
package flash_port_pkg;
	localparam int INSTR_BITS = 20;
	localparam int PTR_W = 22;
	localparam int LATCH_W = 8;
	localparam int ROW_BITS = 6;
	localparam logic [3:0] CMD_CORE = 4'h0;
	localparam logic [3:0] CMD_SHIFT_LATCH = 4'h2;
	localparam logic [3:0] CMD_RD = 4'h8;
	localparam logic [3:0] CMD_RD_INC = 4'h9;
	localparam logic [3:0] CMD_RD_DEC = 4'hA;
	localparam logic [3:0] CMD_RD_PRE = 4'hB;
	localparam logic [3:0] CMD_WR = 4'hC;
	localparam logic [3:0] CMD_WR_INC = 4'hD;
	localparam logic [3:0] CMD_WR_PROG_INC = 4'hE;
	localparam logic [3:0] CMD_WR_PROG = 4'hF;
	localparam logic [4:0] CNT_CMD_LAST = 5'h03;
	localparam logic [4:0] CNT_OUT_FIRST = 5'h0C;
	localparam logic [4:0] CNT_LAST = 5'h13;
	localparam logic [21:0] PTR_STEP1 = 22'h000001;
	localparam logic [21:0] PTR_STEP2 = 22'h000002;
	localparam logic [21:0] KEY1_ADDR = 22'h3C0005;
	localparam logic [15:0] KEY1_DATA = 16'h3F3F;
	localparam logic [21:0] KEY2_ADDR = 22'h3C0004;
	localparam logic [15:0] KEY2_DATA = 16'h8F8F;
	localparam logic [7:0] OFS_PTR = 8'h00;
	localparam logic [7:0] OFS_LATCH = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_CORE = 8'h10;
	localparam int CTRL_WS_BIT = 0;
	localparam int CTRL_WE_BIT = 1;
	localparam int CTRL_FREE_BIT = 2;
	localparam int CTRL_PROT_BIT = 3;
	localparam int STAT_ERR_BIT = 12;
	localparam int CORE_NEW_BIT = 16;
	localparam logic [21:0] PTR_RST = 22'h000000;
	localparam logic [7:0] LATCH_RST = 8'h00;
	typedef enum logic [2:0] {
		ST_SHIFT = 3'b001,
		ST_FETCH = 3'b010,
		ST_HOLD = 3'b100
	} ctl_state_e;
	typedef struct packed {
		logic [21:0] addr;
		logic [15:0] data;
	} mem_wr_s;
	typedef struct packed {
		logic active;
		logic erase;
		logic [21:0] addr;
	} prog_s;
endpackage : flash_port_pkg

// [rtl/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 2
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] lvl,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sync_s;
	sync_s q;
	sync_s n;
	always_comb begin
		n = q;
		n.s1 = d_in;
		n.s2 = q.s1;
		n.s3 = q.s2;
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
	// edges only from the second and third stages
	assign lvl = q.s2;
	assign rise = q.s2 & ~q.s3;
	assign fall = ~q.s2 & q.s3;
endmodule : pin_sync

// [rtl/serial_flash_program_port.sv]
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module serial_flash_program_port
	import flash_port_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic prog_clock_pin,
	input wire logic prog_data_pin_in,
	output logic prog_data_pin_out,
	output logic prog_data_pin_oe,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] core_instr,
	output logic core_instr_valid,
	output logic mem_rd_req,
	output logic [21:0] mem_rd_addr,
	input wire logic [7:0] mem_rd_data,
	output mem_wr_s wbuf_wr,
	output logic wbuf_wr_valid,
	output prog_s prog,
	output logic bulk_erase_busy,
	input wire logic bulk_erase_done
);
	typedef struct packed {
		ctl_state_e state;
		logic [4:0] cnt;
		logic [19:0] sh;
		logic [3:0] cmd;
		logic [21:0] ptr;
		logic [7:0] latch;
		logic dout;
		logic doe;
		logic [15:0] core_instr;
		logic core_valid;
		logic core_new;
		logic wbuf_valid;
		mem_wr_s wbuf;
		logic rd_req;
		logic [21:0] rd_addr;
		logic armed;
		prog_s prog;
		logic key_stage;
		logic bulk_erase;
		logic prot_err;
		logic ctrl_ws;
		logic ctrl_we;
		logic ctrl_free;
		logic ctrl_prot;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} port_s;

	port_s q;
	port_s n;
	logic [1:0] pin_lvl;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;
	logic pgc_lvl;
	logic pgc_rise;
	logic pgc_fall;
	logic pgd_lvl;
	logic [19:0] word;
	logic [4:0] oidx;
	logic apb_done;
	logic start_ok;
	logic use_ctrl;

	function automatic logic rd_class(input logic [3:0] c);
		rd_class = (c == CMD_SHIFT_LATCH) || (c[3:2] == 2'b10);
	endfunction : rd_class

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == OFS_PTR) || (a == OFS_LATCH) || (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_CORE);
	endfunction : reg_hit

	// both pins cross from the programmer's timing into sys_clk
	pin_sync #(
		.W(2)
	) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.d_in({prog_data_pin_in, prog_clock_pin}),
		.lvl(pin_lvl),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	assign pgc_lvl = pin_lvl[0];
	assign pgc_rise = pin_rise[0];
	assign pgc_fall = pin_fall[0];
	assign pgd_lvl = pin_lvl[1];
	assign word = {pgd_lvl, q.sh[19:1]};
	assign oidx = q.cnt - CNT_OUT_FIRST;
	assign apb_done = psel && penable && q.pready;
	assign use_ctrl = !q.armed && q.ctrl_ws && q.ctrl_we;
	assign start_ok = !(use_ctrl && q.ctrl_free && q.ctrl_prot);

	always_comb begin
		n = q;
		n.core_valid = 1'b0;
		n.wbuf_valid = 1'b0;
		n.rd_req = 1'b0;
		n.pready = 1'b0;
		// one wait state so read data can come from a flop
		if (psel && penable && !q.pready) begin
			n.pready = 1'b1;
			n.pslverr = !reg_hit(paddr);
			n.prdata = 32'h00000000;
			case (paddr)
				OFS_PTR: n.prdata = {10'h000, q.ptr};
				OFS_LATCH: n.prdata = {24'h000000, q.latch};
				OFS_CTRL: n.prdata = {28'h0000000, q.ctrl_prot, q.ctrl_free, q.ctrl_we, q.ctrl_ws};
				OFS_STATUS: n.prdata = {19'h00000, q.prot_err, q.bulk_erase, q.key_stage, q.prog.active,
					q.armed, q.state, q.cnt};
				OFS_CORE: n.prdata = {15'h0000, q.core_new, q.core_instr};
				default: n.prdata = 32'h00000000;
			endcase
		end
		if (apb_done && pwrite) begin
			case (paddr)
				OFS_PTR: n.ptr = pwdata[21:0];
				OFS_LATCH: n.latch = pwdata[7:0];
				OFS_CTRL: begin
					n.ctrl_ws = pwdata[CTRL_WS_BIT];
					n.ctrl_we = pwdata[CTRL_WE_BIT];
					n.ctrl_free = pwdata[CTRL_FREE_BIT];
					n.ctrl_prot = pwdata[CTRL_PROT_BIT];
				end
				OFS_STATUS: begin
					if (pwdata[STAT_ERR_BIT]) begin
						n.prot_err = 1'b0;
					end
				end
				OFS_CORE: begin
					if (pwdata[CORE_NEW_BIT]) begin
						n.core_new = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (bulk_erase_done) begin
			n.bulk_erase = 1'b0;
		end

		// serial engine; placed after the bus so hardware sets win
		case (q.state)
			ST_SHIFT: begin
				if (pgc_rise) begin
					if ((q.armed || use_ctrl) && q.cnt == CNT_CMD_LAST) begin
						n.state = ST_HOLD;
						n.armed = 1'b0;
						n.ctrl_ws = 1'b0;
						if (start_ok) begin
							n.prog.active = 1'b1;
							n.prog.erase = use_ctrl && q.ctrl_free;
							n.prog.addr = q.ptr;
							if (use_ctrl && q.ctrl_free) begin
								n.prog.addr = {q.ptr[21:ROW_BITS], {ROW_BITS{1'b0}}};
							end
						end else begin
							n.prot_err = 1'b1;
						end
					end else if (rd_class(q.cmd) && q.cnt >= CNT_OUT_FIRST) begin
						n.dout = q.latch[oidx[2:0]];
						n.doe = 1'b1;
					end
				end
			end
			ST_FETCH: begin
				n.latch = mem_rd_data;
				n.state = ST_SHIFT;
				case (q.cmd)
					CMD_RD_INC: n.ptr = q.ptr + PTR_STEP1;
					CMD_RD_DEC: n.ptr = q.ptr - PTR_STEP1;
					CMD_RD_PRE: n.ptr = q.ptr + PTR_STEP1;
					default: n.ptr = q.ptr;
				endcase
			end
			ST_HOLD: begin
				// the held-high clock is the programming time
			end
			default: n.state = ST_SHIFT;
		endcase

		if (pgc_fall) begin
			n.sh = word;
			if (q.state == ST_HOLD) begin
				n.state = ST_SHIFT;
				n.prog.active = 1'b0;
			end
			if (q.cnt == CNT_LAST) begin
				n.cnt = 5'h00;
				n.doe = 1'b0;
				case (q.cmd)
					CMD_CORE: begin
						n.core_instr = word[19:4];
						n.core_valid = 1'b1;
						n.core_new = 1'b1;
					end
					CMD_WR, CMD_WR_INC, CMD_WR_PROG_INC, CMD_WR_PROG: begin
						n.wbuf_valid = 1'b1;
						n.wbuf.addr = q.ptr;
						n.wbuf.data = word[19:4];
						if (q.cmd == CMD_WR_INC || q.cmd == CMD_WR_PROG_INC) begin
							n.ptr = q.ptr + PTR_STEP2;
						end
						if (q.cmd == CMD_WR_PROG_INC || q.cmd == CMD_WR_PROG) begin
							n.armed = 1'b1;
						end
						n.key_stage = 1'b0;
						if (q.cmd == CMD_WR && q.ptr == KEY1_ADDR && word[19:4] == KEY1_DATA) begin
							n.key_stage = 1'b1;
						end
						if (q.cmd == CMD_WR && q.key_stage && q.ptr == KEY2_ADDR && word[19:4] == KEY2_DATA) begin
							n.bulk_erase = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end else begin
				n.cnt = q.cnt + 5'h01;
				if (q.cnt == CNT_CMD_LAST) begin
					n.cmd = word[19:16];
					if (word[19:18] == 2'b10) begin
						n.state = ST_FETCH;
						n.rd_req = 1'b1;
						n.rd_addr = (word[19:16] == CMD_RD_PRE) ? q.ptr + PTR_STEP1 : q.ptr;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
			q.state <= ST_SHIFT;
			q.ptr <= PTR_RST;
			q.latch <= LATCH_RST;
		end else begin
			q <= n;
		end
	end

	assign prog_data_pin_out = q.dout;
	assign prog_data_pin_oe = q.doe;
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign core_instr = q.core_instr;
	assign core_instr_valid = q.core_valid;
	assign mem_rd_req = q.rd_req;
	assign mem_rd_addr = q.rd_addr;
	assign wbuf_wr = q.wbuf;
	assign wbuf_wr_valid = q.wbuf_valid;
	assign prog = q.prog;
	assign bulk_erase_busy = q.bulk_erase;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	chk_oe_read_only: assert property (q.doe |-> rd_class(q.cmd) && q.cnt >= CNT_OUT_FIRST)
		else $error("data pin driven outside output half");
	chk_first_out_lsb: assert property ($rose(q.doe) |-> q.dout == q.latch[0] && q.cnt == CNT_OUT_FIRST)
		else $error("first output bit is not latch bit 0");
	chk_cnt_range: assert property (q.cnt <= CNT_LAST)
		else $error("bit counter beyond instruction length");
	chk_core_exec: assert property (q.core_valid |-> $past(pgc_fall) && $past(q.cnt) == CNT_LAST
		&& $past(q.cmd) == CMD_CORE)
		else $error("core instruction issued early");
	chk_wbuf_exec: assert property (q.wbuf_valid |-> $past(q.cnt) == CNT_LAST && $past(q.cmd[3:2]) == 2'b11)
		else $error("table write before twenty bits");
	chk_read_fetch: assert property (pgc_fall && q.cnt == CNT_CMD_LAST && word[19:18] == 2'b10
		|=> q.state == ST_FETCH && q.rd_req ##1 q.state == ST_SHIFT)
		else $error("table read fetch missing");
	chk_wr_post_inc: assert property (pgc_fall && q.cnt == CNT_LAST && q.cmd == CMD_WR_INC && !apb_done
		|=> q.ptr == $past(q.ptr) + PTR_STEP2)
		else $error("pointer not advanced by two");
	chk_prog_start: assert property (pgc_rise && q.state == ST_SHIFT && q.armed && q.cnt == CNT_CMD_LAST
		|=> q.prog.active && !q.prog.erase)
		else $error("programming did not start on fourth clock");
	chk_prog_end: assert property (q.prog.active && pgc_fall |=> !q.prog.active)
		else $error("programming outlived the held clock");
	chk_row_align: assert property (q.prog.erase && q.prog.active |-> q.prog.addr[ROW_BITS-1:0] == '0)
		else $error("row erase address not row aligned");
	chk_prot_block: assert property ($rose(q.prog.active) && q.prog.erase |-> !$past(q.ctrl_prot))
		else $error("protected row erased");
	chk_bulk_key: assert property ($rose(q.bulk_erase) |-> $past(q.key_stage) && $past(q.ptr) == KEY2_ADDR)
		else $error("bulk erase without key sequence");
	chk_core_once: assert property (q.core_valid |=> !q.core_valid)
		else $error("core instruction strobe longer than one cycle");
	chk_fetch_load: assert property (q.state == ST_FETCH |=> q.latch == $past(mem_rd_data))
		else $error("table latch not loaded from memory");
	chk_oe_drop: assert property (q.doe && pgc_fall && q.cnt == CNT_LAST |=> !q.doe && q.cnt == 5'h00)
		else $error("data pin still driven after instruction end");
	chk_out_bit: assert property (pgc_rise && q.state == ST_SHIFT && rd_class(q.cmd) && q.cnt >= CNT_OUT_FIRST
		|=> q.doe && q.dout == $past(q.latch[oidx[2:0]]))
		else $error("output bit not taken from table latch");
	chk_rd_pre_addr: assert property (pgc_fall && q.cnt == CNT_CMD_LAST && word[19:16] == CMD_RD_PRE
		|=> q.rd_addr == $past(q.ptr) + PTR_STEP1)
		else $error("pre-increment read fetched the old pointer");
	chk_hold_state: assert property (q.prog.active |-> q.state == ST_HOLD)
		else $error("programming active outside the held clock");

	cov_bulk: cover property ($rose(q.bulk_erase));
	cov_row_erase: cover property ($rose(q.prog.active) && q.prog.erase);
	cov_read_out: cover property ($fell(q.doe));
	cov_core: cover property (q.core_valid);
	cov_prot_refused: cover property ($rose(q.prot_err));
endmodule : serial_flash_program_port

// [tb/prog_model.sv]
`timescale 1ns/100ps
module prog_model (
	output logic clk_pin,
	output logic drv,
	input wire logic line
);
	initial begin
		clk_pin = 1'b0;
		drv = 1'b0;
	end
	// clock only runs inside an instruction; idle low
	task automatic xfer(input logic [3:0] cmd, input logic [15:0] opd, input int hold, output logic [7:0] got);
		logic [19:0] w;
		logic rd;
		w = {opd, cmd};
		rd = (cmd == 4'h2) || (cmd[3:2] == 2'b10);
		got = 8'h00;
		// pins move by nonblocking update on the sys_clk edge, so the synchroniser never races them
		for (int i = 0; i < 20; i++) begin
			clk_pin <= 1'b1;
			// released pin toggles so a silent device never matches
			drv <= (rd && i >= 12) ? ~drv : w[i];
			#80;
			if (i == 3) #(hold);
			clk_pin <= 1'b0;
			if (i >= 12) got[i-12] = line;
			#80;
		end
	endtask : xfer
endmodule : prog_model

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
	import flash_port_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bulk_erase_done = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, core_instr_valid, mem_rd_req, wbuf_wr_valid, bulk_erase_busy, e, pa;
	logic [15:0] core_instr;
	logic [21:0] mem_rd_addr;
	logic [7:0] mem_rd_data, got;
	mem_wr_s wbuf_wr, wcap;
	prog_s prog, pcap;
	logic pin_clk, m_drv, pd_out, pd_oe, pd_line;
	int n_fail = 0, num_checks = 0, pcnt = 0, cyc = 0, ccnt = 0, rcnt = 0;
	logic [3:0] rc [5] = '{CMD_RD_INC, CMD_RD_PRE, CMD_RD_DEC, CMD_RD, CMD_SHIFT_LATCH};
	logic [7:0] rb [5] = '{8'h7A, 8'h78, 8'h78, 8'h7B, 8'h7B};
	logic [21:0] rp [5] = '{22'h000121, 22'h000122, 22'h000121, 22'h000121, 22'h000121};
	always #10 sys_clk = ~sys_clk;
	assign pd_line = pd_oe ? pd_out : m_drv;
	// memory answers combinationally from the held address
	assign mem_rd_data = mem_rd_addr[7:0] ^ 8'h5A;
	serial_flash_program_port i_serial_flash_program_port (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.prog_clock_pin(pin_clk), .prog_data_pin_in(pd_line), .prog_data_pin_out(pd_out),
		.prog_data_pin_oe(pd_oe), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_instr(core_instr),
		.core_instr_valid(core_instr_valid), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
		.mem_rd_data(mem_rd_data), .wbuf_wr(wbuf_wr), .wbuf_wr_valid(wbuf_wr_valid), .prog(prog),
		.bulk_erase_busy(bulk_erase_busy), .bulk_erase_done(bulk_erase_done));
	prog_model i_prog_model (.clk_pin(pin_clk), .drv(m_drv), .line(pd_line));
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		pa <= prog.active;
		if (wbuf_wr_valid === 1'b1) wcap <= wbuf_wr;
		if (core_instr_valid === 1'b1) ccnt <= ccnt + 1;
		if (mem_rd_req === 1'b1) rcnt <= rcnt + 1;
		if (prog.active === 1'b1 && pa !== 1'b1) begin
			pcnt <= pcnt + 1;
			pcap <= prog;
		end
		// ceiling well above the few thousand cycles the sequence needs
		if (cyc == 30000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// no local limit: the cycle ceiling ends a hung wait as a mismatch
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("apb read", exp, q);
	endtask : rdchk
	task automatic ser(input logic [3:0] c, input logic [15:0] o, input int h);
		i_prog_model.xfer(c, o, h, got);
		repeat (6) @(posedge sys_clk);
	endtask : ser
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rdchk(OFS_PTR, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		ser(CMD_CORE, 16'h84A6, 0);
		chk("core instr", 32'h84A6, {16'h0, core_instr});
		chk("core pulses", 32'h1, ccnt);
		apb(1'b1, OFS_PTR, 32'h100);
		ser(CMD_WR_INC, 16'h3C40, 0);
		chk("wr addr", 32'h100, {10'h0, wcap.addr});
		chk("wr data", 32'h3C40, {16'h0, wcap.data});
		ser(CMD_WR, 16'h1111, 0);
		chk("wr addr", 32'h102, {10'h0, wcap.addr});
		rdchk(OFS_PTR, 32'h102);
		apb(1'b1, OFS_PTR, 32'h120);
		for (int i = 0; i < 5; i++) begin
			ser(rc[i], 16'h0, 0);
			chk("out byte", {24'h0, rb[i]}, {24'h0, got});
			rdchk(OFS_PTR, {10'h0, rp[i]});
		end
		rdchk(OFS_LATCH, 32'h7B);
		chk("fetches", 32'h4, rcnt);
		apb(1'b1, OFS_PTR, 32'h200);
		ser(CMD_WR_PROG, 16'hBEEF, 0);
		ser(CMD_CORE, 16'h0, 400);
		chk("prog starts", 32'h1, pcnt);
		chk("prog addr", 32'h200, {10'h0, pcap.addr});
		chk("prog ended", 32'h0, {31'h0, prog.active});
		ser(CMD_WR_PROG_INC, 16'h1234, 0);
		ser(CMD_CORE, 16'h0, 400);
		chk("prog starts", 32'h2, pcnt);
		rdchk(OFS_PTR, 32'h202);
		apb(1'b1, OFS_PTR, 32'h345);
		apb(1'b1, OFS_CTRL, 32'h7);
		ser(CMD_CORE, 16'h0, 400);
		chk("row erase", 32'h3, pcnt);
		chk("row addr", 32'h340, {10'h0, pcap.addr});
		chk("row flag", 32'h1, {31'h0, pcap.erase});
		apb(1'b1, OFS_CTRL, 32'hF);
		ser(CMD_CORE, 16'h0, 400);
		chk("protected", 32'h3, pcnt);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("prot err", 32'h1, {31'h0, q[STAT_ERR_BIT]});
		apb(1'b1, OFS_PTR, {10'h0, KEY1_ADDR});
		ser(CMD_WR, KEY1_DATA, 0);
		apb(1'b1, OFS_PTR, {10'h0, KEY2_ADDR});
		ser(CMD_WR, KEY2_DATA, 0);
		chk("bulk busy", 32'h1, {31'h0, bulk_erase_busy});
		bulk_erase_done <= 1'b1;
		@(posedge sys_clk);
		bulk_erase_done <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("bulk done", 32'h0, {31'h0, bulk_erase_busy});
		apb(1'b1, OFS_PTR, 32'h300);
		ser(CMD_WR_PROG, 16'hFFFF, 0);
		ser(CMD_CORE, 16'h0, 400);
		chk("ones data", 32'hFFFF, {16'h0, wcap.data});
		chk("prog starts", 32'h4, pcnt);
		chk("prog addr", 32'h300, {10'h0, pcap.addr});
		ser(CMD_RD, 16'h0, 0);
		chk("verify byte", 32'h5A, {24'h0, got});
		chk("rd addr", 32'h300, {10'h0, mem_rd_addr});
		conclude();
	end
endmodule : tb
